// ===== logic/ccx_exec.sv
// Executor for clear-working, clear-file, watchdog-restart and complement-file instructions
`timescale 1ns/1ps
// Notes on behaviour
// - The clear-working opcode loads zero into the working register and sets the zero flag.
// - The clear-file opcode writes zero to the file register at its five-bit address and sets zero.
// - The watchdog-restart opcode pulses the watchdog counter clear.
// - That opcode also clears the shared prescaler only while it is assigned to the watchdog.
// - That opcode sets the active-low timeout and power-down status flags to one.
// - The complement opcode produces the bitwise inverse of the addressed file register.
// - Destination bit 0 sends the result to the working register, 1 writes it back to the file.
module ccx_exec #(
    parameter int OPW = ccx_pkg::CCX_OPW
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    // Fetch stage
    input  wire logic                instrValid,
    input  wire logic [OPW-1:0]      instrWord,
    // File register read port, combinational from the addressed register
    output logic [4:0]               fileRdAddr,
    input  wire logic [7:0]          fileRdData,
    // Prescaler assignment: high when assigned to the watchdog
    input  wire logic                prescAtWatchdog,
    // Results
    output ccx_pkg::ccx_fwr_t        fileWr,
    output logic [7:0]               workReg,
    output ccx_pkg::ccx_stat_t       statusOut,
    output logic                     watchdogClr,
    output logic                     prescClr,
    output logic                     execDone
);
    import ccx_pkg::*;

    ccx_kind_t  kind;
    logic [7:0] compRes;
    logic [7:0] work_q;
    ccx_fwr_t   fwr_q;
    ccx_stat_t  stat_q;
    logic       wdClr_q;
    logic       prClr_q;
    logic       done_q;

    // Read address taken straight from the opcode; file data must be valid same cycle
    assign fileRdAddr = instrWord[CCX_ADDR_LSB +: CCX_AW];
    assign compRes    = ~fileRdData;

    always_comb begin
        kind = CCX_NONE;
        if (instrValid) begin
            if (instrWord == CCX_OP_CLRWORK) begin
                kind = CCX_WCLR;
            end else if (instrWord == CCX_OP_WDRESTART) begin
                kind = CCX_WDCLR;
            end else if (instrWord[CCX_CLRFILE_MSB:CCX_CLRFILE_LSB] == CCX_OP_CLRFILE) begin
                kind = CCX_FCLR;
            end else if (instrWord[CCX_CLRFILE_MSB:CCX_COMPL_LSB] == CCX_OP_COMPL) begin
                kind = CCX_COMP;
            end
        end
    end

    // Working register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            work_q <= CCX_WREG_RST;
        end else begin
            case (kind)
                CCX_WCLR: work_q <= CCX_ZERO;
                CCX_COMP: begin
                    if (!instrWord[CCX_DEST_BIT]) begin
                        work_q <= compRes;
                    end
                end
                default: work_q <= work_q;
            endcase
        end
    end

    // File write strobe, one cycle per clear-file or file-destination complement instruction
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fwr_q <= '0;
        end else begin
            fwr_q.addr <= instrWord[CCX_ADDR_LSB +: CCX_AW];
            case (kind)
                CCX_FCLR: begin
                    fwr_q.we   <= 1'b1;
                    fwr_q.data <= CCX_ZERO;
                end
                CCX_COMP: begin
                    fwr_q.we   <= instrWord[CCX_DEST_BIT];
                    fwr_q.data <= compRes;
                end
                default: begin
                    fwr_q.we   <= 1'b0;
                    fwr_q.data <= CCX_ZERO;
                end
            endcase
        end
    end

    // Status flags; zero flag is a write pulse, power flags are held levels
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_q.zero       <= 1'b0;
            stat_q.zeroWe     <= 1'b0;
            stat_q.timeoutN   <= CCX_FLAG_N_RST;
            stat_q.powerdownN <= CCX_FLAG_N_RST;
        end else begin
            case (kind)
                CCX_WCLR, CCX_FCLR: begin
                    stat_q.zero   <= 1'b1;
                    stat_q.zeroWe <= 1'b1;
                end
                CCX_COMP: begin
                    stat_q.zero   <= (compRes == CCX_ZERO);
                    stat_q.zeroWe <= 1'b1;
                end
                CCX_WDCLR: begin
                    stat_q.zeroWe     <= 1'b0;
                    stat_q.timeoutN   <= 1'b1;
                    stat_q.powerdownN <= 1'b1;
                end
                default: stat_q.zeroWe <= 1'b0;
            endcase
        end
    end

    // Watchdog and prescaler clear pulses
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdClr_q <= 1'b0;
            prClr_q <= 1'b0;
        end else begin
            wdClr_q <= (kind == CCX_WDCLR);
            prClr_q <= (kind == CCX_WDCLR) && prescAtWatchdog;
        end
    end

    // Single-cycle completion, no stall ever
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (kind != CCX_NONE);
        end
    end

    assign workReg     = work_q;
    assign fileWr      = fwr_q;
    assign statusOut   = stat_q;
    assign watchdogClr = wdClr_q;
    assign prescClr    = prClr_q;
    assign execDone    = done_q;
endmodule

// ===== logic/ccx_pkg.sv
// Package: opcodes, field layout and carrier types for the clear/complement executor
package ccx_pkg;
    localparam int          CCX_OPW          = 12;
    localparam int          CCX_DW           = 8;
    localparam int          CCX_AW           = 5;
    localparam logic [11:0] CCX_OP_CLRWORK   = 12'h040;
    localparam logic [11:0] CCX_OP_WDRESTART = 12'h004;
    localparam logic [6:0]  CCX_OP_CLRFILE   = 7'h03;
    localparam int          CCX_CLRFILE_MSB  = 11;
    localparam int          CCX_CLRFILE_LSB  = 5;
    localparam logic [5:0]  CCX_OP_COMPL     = 6'h09;
    localparam int          CCX_COMPL_LSB    = 6;
    localparam int          CCX_DEST_BIT     = 5;
    localparam int          CCX_ADDR_LSB     = 0;
    localparam logic [7:0]  CCX_WREG_RST     = 8'h00;
    localparam logic        CCX_FLAG_N_RST   = 1'b1;
    localparam logic [7:0]  CCX_ZERO         = 8'h00;

    typedef enum logic [4:0] {
        CCX_NONE   = 5'b00001,
        CCX_WCLR   = 5'b00010,
        CCX_FCLR   = 5'b00100,
        CCX_WDCLR  = 5'b01000,
        CCX_COMP   = 5'b10000
    } ccx_kind_t;

    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [7:0] data;
    } ccx_fwr_t;

    typedef struct packed {
        logic zero;
        logic zeroWe;
        logic timeoutN;
        logic powerdownN;
    } ccx_stat_t;
endpackage

// ===== tb/ccx_exec_chk.sv
// Checker: port properties of the executor
`timescale 1ns/1ps
module ccx_exec_chk #(parameter int OPW = 12) (
    // Clock, reset
    input wire logic clk,
    input wire logic rstn,
    // Fetch, file read
    input wire logic instrValid,
    input wire logic [OPW-1:0] instrWord,
    input wire logic [7:0] fileRdData,
    input wire logic prescAtWatchdog,
    // Results
    input wire ccx_pkg::ccx_fwr_t fileWr,
    input wire logic [7:0] workReg,
    input wire ccx_pkg::ccx_stat_t statusOut,
    input wire logic watchdogClr,
    input wire logic prescClr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence sWd; instrValid && instrWord == 12'h004; endsequence
    sequence sComp; instrValid && instrWord[11:6] == 6'h09; endsequence
    a_wd_clear: assert property (sWd |=> watchdogClr)
        else $error("watchdog clear missing");
    a_presc_gate: assert property (sWd |=> prescClr == $past(prescAtWatchdog))
        else $error("prescaler clear wrong");
    a_wd_flags: assert property (sWd |=> statusOut.timeoutN && statusOut.powerdownN)
        else $error("status flags not set");
    a_clr_work: assert property (instrValid && instrWord == 12'h040
        |=> workReg == 8'h00 && statusOut.zero && statusOut.zeroWe) else $error("clear work");
    a_clr_file: assert property (instrValid && instrWord[11:5] == 7'h03 |=> fileWr.we
        && fileWr.data == 8'h00 && fileWr.addr == $past(instrWord[4:0]) && statusOut.zero)
        else $error("clear file");
    a_comp_value: assert property (sComp
        |=> (fileWr.we ? fileWr.data : workReg) == ~$past(fileRdData)) else $error("complement");
    a_comp_dest: assert property (sComp |=> fileWr.we == $past(instrWord[5]))
        else $error("destination wrong");
    a_comp_zero: assert property (sComp |=> statusOut.zeroWe
        && statusOut.zero == ($past(fileRdData) == 8'hff)) else $error("zero flag wrong");
endmodule

// ===== tb/ccx_file_model.sv
// Partner model: file register bank
`timescale 1ns/1ps
module ccx_file_model (
    // Clock
    input wire logic clk,
    // Ports to the executor
    input wire logic [4:0] rdAddr,
    output logic [7:0] rdData,
    input wire ccx_pkg::ccx_fwr_t fileWr
);
    logic [7:0] mem [32];
    initial for (int i = 0; i < 32; i++) mem[i] = 8'h13 + 8'(i);
    assign rdData = mem[rdAddr];
    always @(posedge clk) if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
endmodule

// ===== tb/ccx_exec_test.sv
// Testbench: instruction sequences for the executor
`timescale 1ns/1ps
module ccx_exec_test;
    import ccx_pkg::*;
    logic clk = 0, rstn = 0, instrValid = 0, prescAtWatchdog = 0;
    logic [11:0] instrWord = 12'h000;
    logic [4:0] fileRdAddr;
    logic [7:0] fileRdData, workReg;
    ccx_fwr_t fileWr;
    ccx_stat_t statusOut;
    logic watchdogClr, prescClr, execDone;
    int fail_count = 0, num_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    ccx_file_model fm (.clk(clk), .rdAddr(fileRdAddr), .rdData(fileRdData), .fileWr(fileWr));
    ccx_exec dut (.*);
    task chk(logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task run(logic [11:0] op, logic pa);
        @(posedge clk);
        instrValid <= 1'b1;
        instrWord <= op;
        prescAtWatchdog <= pa;
        @(posedge clk);
        instrValid <= 1'b0;
        #1;
    endtask
    // File bank takes the write one edge after the executor shows it
    task settle;
        @(posedge clk);
        #1;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, well above the few dozen cycles used
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        run(12'h240, 1'b0);
        chk(workReg, 8'hec);
        chk(fm.mem[0], 8'h13);
        chk(execDone, 8'h01);
        run(12'h261, 1'b0);
        settle();
        chk(fm.mem[1], 8'heb);
        run(12'h040, 1'b0);
        chk({workReg, 7'h00, statusOut.zero}, 16'h0001);
        $display("test done: complement and clear working");
        run(12'h07f, 1'b0);
        settle();
        chk({fm.mem[31], 7'h00, statusOut.zero}, 16'h0001);
        run(12'h27f, 1'b0);
        settle();
        chk({fm.mem[31], 7'h00, statusOut.zero}, 16'hff00);
        run(12'h25f, 1'b0);
        chk({workReg, 7'h00, statusOut.zero}, 16'h0001);
        run(12'h004, 1'b1);
        chk({watchdogClr, prescClr, statusOut.timeoutN, statusOut.powerdownN}, 8'h0f);
        run(12'h004, 1'b0);
        chk({watchdogClr, prescClr, statusOut.timeoutN, statusOut.powerdownN}, 8'h0b);
        run(12'h041, 1'b0);
        chk({execDone, watchdogClr, fileWr.we}, 8'h00);
        $display("test done: clear file and watchdog restart");
        summarize();
    end
endmodule
bind ccx_exec ccx_exec_chk #(.OPW(OPW)) chk (.*);
